// File: serial_rx_pkg.sv
// Purpose: Constants and types for the asynchronous serial receiver.
// Assumes: Registers sit on 32-bit Avalon-MM words, data in bits 7:0.
// Notes:   Summary of operation follows.
package serial_rx_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_RX_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_BAUD_CONTROL      = 5'h04;
  localparam logic [4:0] OFS_RX_DATA_PORT      = 5'h08;
  localparam logic [4:0] OFS_BAUD_DIVISOR_LOW  = 5'h0c;
  localparam logic [4:0] OFS_BAUD_DIVISOR_HIGH = 5'h10;
  localparam logic [4:0] OFS_TX_STATUS_CONTROL = 5'h14;
  localparam logic [4:0] OFS_IRQ_CONTROL       = 5'h18;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_PORT_EN   = 7;  // Serial port enable
  localparam int BIT_NINE_EN   = 6;  // Nine-bit receive enable
  localparam int BIT_CONT_EN   = 4;  // Continuous receive enable
  localparam int BIT_FRAME_ERR = 2;  // Framing error, head entry
  localparam int BIT_OVERRUN   = 1;  // Overrun error
  localparam int BIT_NINTH     = 0;  // Ninth bit, head entry
  localparam int BIT_RX_IDLE   = 6;  // Receiver idle in baud control
  localparam int BIT_SYNC_SEL  = 4;  // Synchronous select in tx control
  localparam int BIT_RX_IE     = 0;  // Receive interrupt enable
  localparam int BIT_PERIPH_IE = 1;  // Peripheral interrupt enable
  localparam int BIT_GLOBAL_IE = 2;  // Global interrupt enable
  localparam int BIT_PENDING   = 3;  // Receive pending flag
  // ------------------------------------------------------------
  // Reset values and timing counts
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [3:0] OVS_LAST      = 4'hf;  // Sixteen ticks a bit
  localparam logic [3:0] OVS_VOTE_A    = 4'h7;  // Three samples at centre
  localparam logic [3:0] OVS_VOTE_B    = 4'h8;
  localparam logic [3:0] OVS_VOTE_C    = 4'h9;
  localparam logic [3:0] DATA_BITS_8   = 4'h8;
  localparam logic [3:0] DATA_BITS_9   = 4'h9;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_type;
  typedef struct packed {
    logic       frame_err;  // Stop bit sampled low
    logic       ninth;      // Ninth data bit
    logic [7:0] data;       // Low eight data bits
  } rx_entry_type;
  typedef struct packed {
    logic port_en;
    logic nine_en;
    logic cont_en;
    logic sync_sel;
    logic rx_ie;
    logic periph_ie;
    logic global_ie;
  } rx_config_type;
endpackage

// File: serial_rx.sv
// Purpose: Asynchronous serial receiver with two-deep FIFO.
// Assumes: Serial input synchronous to clk_in; Avalon-MM slave.
// Notes:   Waitrequest drops in the cycle after a request is seen.
`timescale 1ns/1ns
`default_nettype none
module serial_rx
  import serial_rx_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        serial_receive_pin_in,
  input  wire logic [4:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  output logic             rx_irq_out
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int CW = $clog2(DEPTH + 1);          // Count width
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  rx_config_type cfg;                 // Software controls
  logic [15:0]   baud_divisor;        // Ticks every divisor+1 clocks
  logic [15:0]   div_count;           // Tick down-counter
  logic          tick;                // One-cycle 16x tick
  rx_state_type  state;               // Recovery state
  logic [3:0]    ovs;                 // Tick within bit
  logic [3:0]    bit_count;           // Data bits shifted
  logic [1:0]    votes;               // First two centre samples
  logic [8:0]    receive_shift_register;
  logic          line_prev;           // Line one cycle ago
  rx_entry_type  fifo [DEPTH];        // Character storage
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;               // Entries held
  logic          overrun_error_flag;
  logic          receive_pending_flag;
  logic          rx_on;               // Asynchronous receive mode
  logic          vote;                // Majority of three samples
  logic          bit_decide;          // Centre decision cycle
  logic          stop_done;           // Stop bit resolved
  logic          push;                // Character into FIFO
  logic          pop;                 // Data port read accepted
  logic          bus_req;             // Any request
  logic          bus_take;            // Request accepted this edge
  logic          bus_wr;              // Accepted write, lane 0
  logic [7:0]    wbyte;
  logic [3:0]    nbits;
  rx_entry_type  head;                // Oldest entry
  rx_entry_type  wentry;              // Entry being written
  logic [31:0]   next_readdata;

  // Majority of three samples
  function automatic logic majority(input logic a, input logic b,
                                    input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // Pointer advance with wrap at DEPTH
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // ------------------------------------------------------------
  // Mode and bus decode
  // ------------------------------------------------------------
  // mode select gate
  assign rx_on   = cfg.cont_en & cfg.port_en & ~cfg.sync_sel;
  assign bus_req = read_in | write_in;
  // Accepted only at the edge where waitrequest is low
  assign bus_take = bus_req & ~waitrequest_out;
  assign bus_wr   = bus_take & write_in & byteenable_in[0];
  assign wbyte    = writedata_in[7:0];
  assign pop  = bus_take & read_in & (address_in == OFS_RX_DATA_PORT)
                & (count != '0);
  assign head = fifo[rd_ptr];
  assign nbits = cfg.nine_en ? DATA_BITS_9 : DATA_BITS_8;

  // ------------------------------------------------------------
  // Bus handshake: one wait cycle per request
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waitrequest_out <= 1'b1;
    end else begin
      // Drop for one cycle once a request is seen
      waitrequest_out <= ~(bus_req & waitrequest_out);
    end
  end

  // Read data mux; unmapped words read zero
  always_comb begin
    next_readdata = '0;
    unique case (address_in)
      OFS_RX_STATUS_CONTROL: begin
        next_readdata[BIT_PORT_EN]   = cfg.port_en;
        next_readdata[BIT_NINE_EN]   = cfg.nine_en;
        next_readdata[BIT_CONT_EN]   = cfg.cont_en;
        next_readdata[BIT_FRAME_ERR] = head.frame_err & (count != '0);
        next_readdata[BIT_OVERRUN]   = overrun_error_flag;
        next_readdata[BIT_NINTH]     = head.ninth & (count != '0);
      end
      OFS_BAUD_CONTROL:
        next_readdata[BIT_RX_IDLE] = (state == ST_IDLE);
      OFS_RX_DATA_PORT:
        next_readdata[7:0] = (count != '0) ? head.data : RST_BYTE;
      OFS_BAUD_DIVISOR_LOW:  next_readdata[7:0] = baud_divisor[7:0];
      OFS_BAUD_DIVISOR_HIGH: next_readdata[7:0] = baud_divisor[15:8];
      OFS_TX_STATUS_CONTROL:
        next_readdata[BIT_SYNC_SEL] = cfg.sync_sel;
      OFS_IRQ_CONTROL: begin
        next_readdata[BIT_RX_IE]     = cfg.rx_ie;
        next_readdata[BIT_PERIPH_IE] = cfg.periph_ie;
        next_readdata[BIT_GLOBAL_IE] = cfg.global_ie;
        next_readdata[BIT_PENDING]   = receive_pending_flag;
      end
      default: next_readdata = '0;
    endcase
  end

  // Read data registered while waitrequest is high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      readdata_out <= '0;
    end else if (bus_req & waitrequest_out & read_in) begin
      readdata_out <= next_readdata;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg          <= '0;
      baud_divisor <= {RST_BYTE, RST_BYTE};
    end else if (bus_wr) begin
      unique case (address_in)
        OFS_RX_STATUS_CONTROL: begin
          cfg.port_en <= wbyte[BIT_PORT_EN];
          cfg.nine_en <= wbyte[BIT_NINE_EN];
          cfg.cont_en <= wbyte[BIT_CONT_EN];
        end
        OFS_BAUD_DIVISOR_LOW:  baud_divisor[7:0]  <= wbyte;
        OFS_BAUD_DIVISOR_HIGH: baud_divisor[15:8] <= wbyte;
        OFS_TX_STATUS_CONTROL: cfg.sync_sel <= wbyte[BIT_SYNC_SEL];
        OFS_IRQ_CONTROL: begin
          cfg.rx_ie     <= wbyte[BIT_RX_IE];
          cfg.periph_ie <= wbyte[BIT_PERIPH_IE];
          cfg.global_ie <= wbyte[BIT_GLOBAL_IE];
        end
        // Read-only and unmapped words ignore writes
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Oversampling tick
  // ------------------------------------------------------------
  // divisor counted on clk_in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_count <= '0;
    end else if (!rx_on || div_count == '0) begin
      // Reload keeps the tick phase fresh after enable
      div_count <= baud_divisor;
    end else begin
      div_count <= div_count - 16'(1);
    end
  end
  assign tick = rx_on & (div_count == '0);

  // ------------------------------------------------------------
  // Data recovery
  // ------------------------------------------------------------
  // centre decision and vote
  assign bit_decide = tick & (ovs == OVS_VOTE_C);
  assign vote = majority(votes[0], votes[1], serial_receive_pin_in);
  assign stop_done = bit_decide & (state == ST_STOP);

  // Line history for edge detection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_prev <= 1'b1;
    end else begin
      line_prev <= serial_receive_pin_in;
    end
  end

  // Recovery state machine
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= ST_IDLE;
      ovs       <= '0;
      bit_count <= '0;
    end else if (!rx_on) begin
      // Leaving the mode abandons any partial character
      state <= ST_IDLE;
    end else begin
      // sixteen ticks per bit
      // Placed ahead of the case so that the restart below wins over it
      if (tick) begin
        ovs <= (ovs == OVS_LAST) ? '0 : ovs + 4'(1);
      end
      unique case (state)
        ST_IDLE: begin
          if (line_prev && !serial_receive_pin_in && !overrun_error_flag) begin
            state <= ST_START;
            ovs   <= '0;
          end
        end
        ST_START: begin
          if (bit_decide) begin
            state     <= vote ? ST_IDLE : ST_DATA;
            bit_count <= '0;
          end
        end
        ST_DATA: begin
          if (bit_decide) begin
            bit_count <= bit_count + 4'(1);
            if (bit_count + 4'(1) == nbits) begin
              state <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (bit_decide) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Centre samples ahead of the vote
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      votes <= '0;
    end else if (tick && ovs == OVS_VOTE_A) begin
      votes[0] <= serial_receive_pin_in;
    end else if (tick && ovs == OVS_VOTE_B) begin
      votes[1] <= serial_receive_pin_in;
    end
  end

  // voted bit shifted in, LSB first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      receive_shift_register <= '0;
    end else if (bit_decide && state == ST_DATA) begin
      receive_shift_register <= {vote, receive_shift_register[8:1]};
    end
  end

  // ------------------------------------------------------------
  // Receive FIFO
  // ------------------------------------------------------------
  // push at stop unless full
  assign push = stop_done & (count != FULL_COUNT);
  always_comb begin
    wentry = '0;
    wentry.frame_err = ~vote;
    if (cfg.nine_en) begin
      wentry.ninth = receive_shift_register[8];
      wentry.data  = receive_shift_register[7:0];
    end else begin
      wentry.data  = receive_shift_register[8:1];
    end
  end

  // Storage written by index
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_slot
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          fifo[gi] <= '0;
        end else if (push && wr_ptr == PW'(gi)) begin
          fifo[gi] <= wentry;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      // Simultaneous push and pop keep the count
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // Flags and interrupt
  // ------------------------------------------------------------
  // overrun set, cleared by enable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overrun_error_flag <= 1'b0;
    end else if (stop_done && count == FULL_COUNT && !pop) begin
      // Set wins over the enable clear
      overrun_error_flag <= 1'b1;
    end else if (!cfg.cont_en) begin
      overrun_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      receive_pending_flag <= 1'b0;
    end else begin
      receive_pending_flag <= rx_on & (count != '0);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_irq_out <= 1'b0;
    end else begin
      rx_irq_out <= rx_on & (count != '0) & cfg.rx_ie
                    & cfg.periph_ie & cfg.global_ie;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence seq_edge_seen;
    state == ST_IDLE && rx_on && !overrun_error_flag
      && line_prev && !serial_receive_pin_in;
  endsequence
  sequence seq_false_start;
    state == ST_START && bit_decide && vote && !pop;
  endsequence
  sequence seq_pop_only;
    pop && !push;
  endsequence

  a_mode_gate_idle: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !rx_on |=> state == ST_IDLE)
    else $error("receiver active outside async mode");
  a_edge_starts: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    seq_edge_seen |=> state == ST_START && ovs == 4'h0)
    else $error("falling edge did not open a character");
  a_false_start_drop: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    seq_false_start |=> state == ST_IDLE && !overrun_error_flag
      && $stable(count))
    else $error("false start not dropped silently");
  a_tick_advance: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_on && !tick && state != ST_IDLE |=> $stable(ovs))
    else $error("oversample moved without a tick");
  a_push_counts: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    stop_done && count == CW'(0) && !pop |=> count == CW'(1)
      ##1 receive_pending_flag)
    else $error("finished character not stored");
  a_read_pops: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    seq_pop_only |=> count == $past(count) - CW'(1))
    else $error("data port read did not pop");
  a_fifo_bound: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    count <= FULL_COUNT)
    else $error("fifo count above depth");
  a_overrun_set: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    stop_done && count == FULL_COUNT && !pop |=> overrun_error_flag
      && count == FULL_COUNT)
    else $error("overrun not flagged");
  a_overrun_blocks: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    overrun_error_flag && state == ST_IDLE |=> state == ST_IDLE)
    else $error("character accepted during overrun");
  a_irq_gated: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_irq_out |-> $past(cfg.rx_ie && cfg.periph_ie && cfg.global_ie
      && count != '0))
    else $error("interrupt without all enables");
endmodule  // serial_rx
`default_nettype wire

// File: serial_tx_model.sv
// Purpose: Remote asynchronous transmitter that drives the receive line.
// Assumes: Bit time is given in system clocks; the line idles high.
// Notes:   Short-pulse mode fakes a start edge that fails its mid-bit check.
`timescale 1ns/1ns
`default_nettype none
module serial_tx_model (
  input  wire logic clk_in,   // System clock
  output var  logic line_out  // Serial line toward the receiver
);
  // Idle level is high, so the receiver sees no edge at start-up
  initial line_out = 1'b1;
  // ----------------------------------------------------------
  // Frame sender: start, data LSB first, stop at chosen level
  // ----------------------------------------------------------
  task automatic send(input logic [8:0] w, input int nb, input logic stop, input int bt);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (bt) @(posedge clk_in);
    for (int k = 0; k < nb; k++) begin
      line_out <= w[k];
      repeat (bt) @(posedge clk_in);
    end
    // A low stop here is a deliberate framing fault
    line_out <= stop;
    repeat (bt) @(posedge clk_in);
    line_out <= 1'b1;
  endtask
  // Low for four clocks only: back high before the start is checked
  task automatic glitch();
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (40) @(posedge clk_in);
  endtask
endmodule // serial_tx_model
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the asynchronous serial receiver.
// Assumes: Avalon-MM register access; divisor 0 gives sixteen clocks a bit.
// Notes:   Every bus wait and the whole run are bounded.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import serial_rx_pkg::*;
  localparam int BT = 16;                  // Clocks a bit at divisor 0
  logic        clk_in       = 1'b0;        // System clock
  logic        rst_n_in     = 1'b0;        // Reset, active low
  logic        read_in      = 1'b0;        // Bus read strobe
  logic        write_in     = 1'b0;        // Bus write strobe
  logic [4:0]  address_in   = 5'h00;       // Byte address
  logic [31:0] writedata_in = 32'h0;       // Write data
  logic [31:0] readdata_out;               // Read data
  logic        waitrequest_out;            // Bus stall
  logic        rx_irq_out;                 // Interrupt request
  wire  logic  line;                       // Serial line
  int          err_count    = 0;           // Mismatches
  int          tests_run    = 0;           // Comparisons
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------
  // Design and far-side transmitter
  // ----------------------------------------------------------
  serial_rx #(.DEPTH(2)) serial_rx_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .serial_receive_pin_in(line), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(4'hf),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .rx_irq_out(rx_irq_out));
  // pin used purely as a digital input
  serial_tx_model serial_tx_model_i (.clk_in(clk_in), .line_out(line));
  // ----------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: irq %b expected %b", $time, got, exp);
    end
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    write_in <= w;
    read_in <= !w;
    address_in <= a;
    writedata_in <= {24'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  // Whole-run limit
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    wrap_up();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Reset state, unmapped word and interrupt request all read zero
    rd(OFS_RX_STATUS_CONTROL, 32'h0);
    rd(OFS_BAUD_DIVISOR_LOW, 32'h0);
    rd(OFS_TX_STATUS_CONTROL, 32'h0);
    rd(OFS_IRQ_CONTROL, 32'h0);
    rd(5'h1c, 32'h0);
    chk_irq(rx_irq_out, 1'b0);
    $display("test reset done");
    wr(OFS_BAUD_DIVISOR_HIGH, 8'hab);
    rd(OFS_BAUD_DIVISOR_HIGH, 32'hab);
    wr(OFS_BAUD_DIVISOR_HIGH, 8'h00);
    wr(OFS_IRQ_CONTROL, 8'h07);
    wr(OFS_RX_DATA_PORT, 8'h12);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    rd(OFS_RX_STATUS_CONTROL, 32'h90);
    rd(OFS_BAUD_CONTROL, 32'h40);
    rd(OFS_RX_DATA_PORT, 32'h0);
    $display("test config done");
    serial_tx_model_i.send(9'h0a5, 8, 1'b1, BT);
    rd(OFS_IRQ_CONTROL, 32'h0f);
    chk_irq(rx_irq_out, 1'b1);
    rd(OFS_RX_STATUS_CONTROL, 32'h90);
    rd(OFS_RX_DATA_PORT, 32'ha5);
    rd(OFS_IRQ_CONTROL, 32'h07);
    serial_tx_model_i.glitch();
    rd(OFS_IRQ_CONTROL, 32'h07);
    rd(OFS_RX_STATUS_CONTROL, 32'h90);
    serial_tx_model_i.send(9'h03c, 8, 1'b0, BT);
    rd(OFS_RX_STATUS_CONTROL, 32'h94);
    rd(OFS_RX_DATA_PORT, 32'h3c);
    $display("test frame done");
    // Each enable pattern: flag stays, request only with all three
    serial_tx_model_i.send(9'h081, 8, 1'b1, BT);
    for (int v = 0; v < 8; v++) begin
      wr(OFS_IRQ_CONTROL, v[7:0]);
      rd(OFS_IRQ_CONTROL, {28'h0, 1'b1, v[2:0]});
      chk_irq(rx_irq_out, v == 7);
    end
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rd(OFS_IRQ_CONTROL, 32'h07);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    rd(OFS_RX_DATA_PORT, 32'h81);
    wr(OFS_TX_STATUS_CONTROL, 8'h10);
    serial_tx_model_i.send(9'h077, 8, 1'b1, BT);
    wr(OFS_TX_STATUS_CONTROL, 8'h00);
    rd(OFS_IRQ_CONTROL, 32'h07);
    $display("test enables done");
    // Four back to back: third overruns, fourth must be ignored
    serial_tx_model_i.send(9'h011, 8, 1'b1, BT);
    serial_tx_model_i.send(9'h022, 8, 1'b1, BT);
    serial_tx_model_i.send(9'h033, 8, 1'b1, BT);
    serial_tx_model_i.send(9'h044, 8, 1'b1, BT);
    rd(OFS_RX_STATUS_CONTROL, 32'h92);
    rd(OFS_RX_DATA_PORT, 32'h11);
    rd(OFS_RX_DATA_PORT, 32'h22);
    rd(OFS_RX_DATA_PORT, 32'h0);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rd(OFS_RX_STATUS_CONTROL, 32'h80);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    serial_tx_model_i.send(9'h055, 8, 1'b1, BT);
    rd(OFS_RX_DATA_PORT, 32'h55);
    $display("test overrun done");
    wr(OFS_RX_STATUS_CONTROL, 8'hd0);
    serial_tx_model_i.send(9'h1c3, 9, 1'b0, BT);
    serial_tx_model_i.send(9'h03c, 9, 1'b1, BT);
    rd(OFS_RX_STATUS_CONTROL, 32'hd5);
    rd(OFS_RX_DATA_PORT, 32'hc3);
    rd(OFS_RX_STATUS_CONTROL, 32'hd0);
    rd(OFS_RX_DATA_PORT, 32'h3c);
    // Divisor 1 doubles the bit time to thirty-two clocks
    wr(OFS_BAUD_DIVISOR_LOW, 8'h01);
    rd(OFS_BAUD_DIVISOR_LOW, 32'h01);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    serial_tx_model_i.send(9'h05a, 8, 1'b1, 2 * BT);
    rd(OFS_RX_DATA_PORT, 32'h5a);
    $display("test nine bit and divisor done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
